/* hw/pll2_lock_loss_status_regs.vh */
/*
 constants for the second loop lock-loss status register.
 assumes the serial port decodes addresses to 13 bits and bytes to 8 bits.
*/
`ifndef PLL2_LOCK_LOSS_STATUS_REGS_VH
`define PLL2_LOCK_LOSS_STATUS_REGS_VH

`define ADDR_W 13
`define DATA_W 8
`define PLL2_LOCK_STATUS_ADDR 13'h0183
`define LOST_CLEAR_BIT 0
`define LOCK_LIVE_BIT 1
`define LOCK_LOST_BIT 2
`define LOST_CLEAR_RESET 1'h0
`define LOCK_LOST_RESET 1'h0
`define RESERVED_FILL 5'h00
`define UNMAPPED_READ 8'h00

`endif

/* hw/pll2_lock_loss_status.v */
/*
 status register of the second loop lock detect: live level, sticky lost flag,
 and a clear control bit, reached through the decoded serial register port.
 assumes the lock detect input and the port strobes are synchronous to sys_clk.
*/
`include "pll2_lock_loss_status_regs.vh"

// Function
// - lost flag sets on lock falling edge
// - clear during low lock leaves flag clear
// - bit 1 reads live lock level
// - clear bit high forces flag to zero
// - clear bit low arms flag for edge
module pll2_lock_loss_status (
    input wire sys_clk,
    input wire rst_b,
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [`DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire second_loop_digital_lock,
    output reg [`DATA_W-1:0] reg_rdata,
    output reg reg_rvalid,
    output reg second_loop_lock_lost_flag,
    output reg second_loop_lost_flag_clear,
    output reg second_loop_lock_live
);

    // decode and edge terms
    wire hit;
    wire write_hit;
    wire read_hit;
    wire lock_fall;
    wire [1:0] lost_cause;
    wire [`DATA_W-1:0] status_word;

    // next values of every register of the block
    reg next_lock_live;
    reg next_clear;
    reg next_lost;
    reg next_rvalid;
    reg [`DATA_W-1:0] next_rdata;

    // only one address belongs to this block; all others fall through
    assign hit = (reg_addr == `PLL2_LOCK_STATUS_ADDR);
    assign write_hit = reg_wr & hit;
    assign read_hit = reg_rd & hit;

    // fall against the registered copy
    // a low level alone never sets, so a clear released while low stays clear
    assign lock_fall = second_loop_lock_live & ~second_loop_digital_lock;

    // held clear in the upper bit so it outranks the edge below
    assign lost_cause = {second_loop_lost_flag_clear, lock_fall};

    // live level in bit 1, reserved bits read zero
    assign status_word = {
        `RESERVED_FILL,
        second_loop_lock_lost_flag,
        second_loop_lock_live,
        second_loop_lost_flag_clear
    };

    // live copy follows the pin one cycle late
    always @* begin
        next_lock_live = second_loop_digital_lock;
    end

    // live copy resets low so a low lock at start is not taken as a fall
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_loop_lock_live <= 1'h0;
        end else begin
            second_loop_lock_live <= next_lock_live;
        end
    end

    always @* begin
        next_clear = second_loop_lost_flag_clear;
        if (write_hit) begin
            next_clear = reg_wdata[`LOST_CLEAR_BIT];
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_loop_lost_flag_clear <= `LOST_CLEAR_RESET;
        end else begin
            second_loop_lost_flag_clear <= next_clear;
        end
    end

    // clear acts from the cycle after its write; a held clear beats any edge
    always @* begin
        next_lost = second_loop_lock_lost_flag;
        case (lost_cause)
            2'h0: begin
                next_lost = second_loop_lock_lost_flag;
            end
            2'h1: begin
                next_lost = 1'h1;
            end
            2'h2: begin
                next_lost = 1'h0;
            end
            2'h3: begin
                next_lost = 1'h0;
            end
            default: begin
                next_lost = second_loop_lock_lost_flag;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_loop_lock_lost_flag <= `LOCK_LOST_RESET;
        end else begin
            second_loop_lock_lost_flag <= next_lost;
        end
    end

    // every read strobe is answered, mapped or not
    always @* begin
        next_rvalid = reg_rd;
    end

    // read byte holds its last value between reads
    always @* begin
        next_rdata = reg_rdata;
        if (read_hit) begin
            next_rdata = status_word;
        end else if (reg_rd) begin
            next_rdata = `UNMAPPED_READ;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `UNMAPPED_READ;
            reg_rvalid <= 1'h0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

endmodule // pll2_lock_loss_status

/* dv/pll2_lock_loss_status_assertions.sv */
/* status port checker; assumes a bind to the status block by port name */
module pll2_lock_loss_status_chk (input wire sys_clk, rst_b, reg_wr, reg_rd, reg_rvalid,
    input wire second_loop_digital_lock, second_loop_lock_lost_flag,
    input wire second_loop_lost_flag_clear, second_loop_lock_live,
    input wire [12:0] reg_addr, input wire [7:0] reg_wdata, reg_rdata);
    timeunit 1ns;
    timeprecision 1ns;
    wire d = second_loop_digital_lock, f = second_loop_lock_lost_flag;
    wire c = second_loop_lost_flag_clear, l = second_loop_lock_live;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_fall_sets: assert property (l && !d && !c |=> f) else $error("no set");
    a_low_quiet: assert property (!f && (d || !l) |=> !f) else $error("set");
    a_live_copy: assert property (1 |=> l == $past(d)) else $error("live");
    a_clear_holds: assert property (c |=> !f) else $error("held");
    a_flag_sticky: assert property (f && !c |=> f) else $error("lost");
    a_rsvd_zero: assert property (reg_rd |=> reg_rvalid && !reg_rdata[7:3]) else $error("rsvd");
endmodule // pll2_lock_loss_status_chk
bind pll2_lock_loss_status pll2_lock_loss_status_chk chk (.*);

/* dv/pll2_lock_loss_status_tb.sv */
/* random bench against a bit model; needs the design and its checker */
module pll2_lock_loss_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CK(n, e, s) begin checks++; if ((e) !== (s)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, d = 1, mf = 0, mc = 0, ml = 0;
    logic f, c, l, reg_rvalid;
    logic [12:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, r;
    int mismatches = 0, checks = 0, lf = 9;
    pll2_lock_loss_status dut (.*, .second_loop_digital_lock(d), .second_loop_lock_live(l),
        .second_loop_lock_lost_flag(f), .second_loop_lost_flag_clear(c));
    always #20 sys_clk = ~sys_clk;
    function int nx(int v); return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #60000 mismatches++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 rst_b = 1;
        `CK("reset", 3'h0, {f, l, c})
        repeat (500) begin
            lf = nx(lf);
            {reg_wdata[0], reg_wr, reg_rd} = lf[2:0];
            d = |lf[4:3];
            reg_addr = lf[5] ? 13'h0183 : 13'h0184;
            @(posedge sys_clk);
            #1;
            // old state feeds the read byte and the lost flag, so update order matters
            r = reg_addr[0] ? {5'h00, mf, ml, mc} : 8'h00;
            mf = !mc && (mf || (ml && !d));
            if (reg_wr && reg_addr[0]) mc = reg_wdata[0];
            ml = d;
            `CK("bits", {mf, ml, mc}, {f, l, c})
            `CK("rvalid", reg_rd, reg_rvalid)
            if (reg_rd) `CK("rdata", r, reg_rdata)
        end
        end_sim;
    end
endmodule // pll2_lock_loss_status_tb
